// [design/clock_ctrl_pkg.sv]
// Package of register map, field layout, reset values and timing for the clock control block.
package clock_ctrl_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_SRC_CFG    = 8'h00;
    localparam logic [7:0] OFS_PLL_MUL    = 8'h04;
    localparam logic [7:0] OFS_DIV_CFG    = 8'h08;
    localparam logic [7:0] OFS_OSC_CTRL   = 8'h0C;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR    = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h1C;
    localparam logic [7:0] OFS_STANDBY    = 8'h20;
    localparam logic [7:0] OFS_STOP_CLR   = 8'h24;

    // Field positions of the source configuration register.
    localparam int SRC_LSB      = 0;
    localparam int EXT_CLK_BIT  = 2;
    localparam int HIRC_HI_BIT  = 4;

    // Field positions of the divider register: one field per derived clock.
    localparam int DIV_STRIDE   = 4;
    localparam int DIV_CORE     = 0;
    localparam int DIV_FAST     = 1;
    localparam int DIV_SLOW     = 2;
    localparam int DIV_CONV     = 3;
    localparam int DIV_FLASH    = 4;
    localparam int DIV_COUNT    = 5;

    // Field positions of the oscillator control and status registers.
    localparam int DET_EN_BIT   = 0;
    localparam int STOP_IRQ_BIT = 1;
    localparam int ST_SRC_LSB   = 0;
    localparam int ST_STOP_BIT  = 2;
    localparam int ST_RUN_BIT   = 3;
    localparam int ST_FREE_BIT  = 4;
    localparam int ST_HIZ_BIT   = 5;

    // Interrupt status bits.
    localparam int IRQ_N          = 3;
    localparam int IRQ_STOP_BIT   = 0;
    localparam int IRQ_REFUSE_BIT = 1;
    localparam int IRQ_STBY_BIT   = 2;

    // Reset values: start on the low-speed oscillator, undivided.
    localparam logic [31:0] SRC_CFG_RST  = 32'h0000_0003;
    localparam logic [4:0]  PLL_MUL_RST  = 5'h08;
    localparam logic [31:0] DIV_CFG_RST  = 32'h0000_0000;
    localparam logic [1:0]  OSC_CTRL_RST = 2'h0;

    // Multiplier in half steps: 8 is times 4, 31 is times 15.5.
    localparam logic [4:0] PLL_MUL_MIN = 5'h08;
    localparam logic [4:0] PLL_MUL_MAX = 5'h1F;

    // Frequencies in kHz.
    localparam int MAIN_MIN_KHZ  = 1000;
    localparam int MAIN_MAX_KHZ  = 20000;
    localparam int HIRC_LO_KHZ   = 32000;
    localparam int HIRC_HI_KHZ   = 64000;
    localparam int LIRC_KHZ      = 4000;
    localparam int CORE_MAX_KHZ  = 80000;
    localparam int FAST_MAX_KHZ  = 80000;
    localparam int SLOW_MAX_KHZ  = 40000;
    localparam int FLASH_MIN_KHZ = 1000;
    localparam int FLASH_MAX_KHZ = 32000;
    localparam int WDT_OSC_KHZ   = 15;

    // Oscillation stop detection time and its cycle count at 50 MHz.
    localparam int CLK_PERIOD_NS = 20;
    localparam int STOP_TIME_NS  = 10000;
    localparam int STOP_CYCLES   = STOP_TIME_NS / CLK_PERIOD_NS;

    // Clock sources in register encoding order.
    typedef enum logic [1:0] {
        SRC_MAIN,
        SRC_PLL,
        SRC_HIRC,
        SRC_LIRC
    } clk_src_t;

endpackage : clock_ctrl_pkg

// [design/clk_div_en.sv]
// Power-of-two divider that turns source ticks into one-cycle clock enables.
`timescale 1ns/1ps
`default_nettype none
module clk_div_en #(
    parameter int DIV_W = 3
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             tick_in,
    input  wire logic [DIV_W-1:0] div_log2,
    output logic                  en_r
);
    localparam int CNT_W = (1 << DIV_W) - 1;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    initial begin
        if (DIV_W < 1 || DIV_W > 4) begin
            $error("clk_div_en: DIV_W out of range");
        end
    end

    // Mask of the counter bits that must all be ones before an enable.
    always_comb begin
        mask = '0;
        for (int i = 0; i < CNT_W; i++) begin
            if (i < int'(div_log2)) begin
                mask[i] = 1'b1;
            end
        end
    end

    // Count source ticks; the enable rises in the cycle after the tick that wraps the count.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= '0;
            en_r  <= 1'b0;
        end else begin
            en_r <= tick_in && ((cnt_r & mask) == mask);
            if (tick_in) begin
                cnt_r <= ((cnt_r & mask) == mask) ? '0 : cnt_r + 1'b1;
            end
        end
    end

endmodule : clk_div_en
`default_nettype wire

// [design/osc_stop_det.sv]
// Watchdog on the main oscillator ticks that flags a stopped oscillator.
`timescale 1ns/1ps
`default_nettype none
module osc_stop_det #(
    parameter int TIMEOUT = 500
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic main_tick,
    output logic      stopped_r
);
    localparam int CNT_W = $clog2(TIMEOUT + 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT);

    logic [CNT_W-1:0] gap_r;

    initial begin
        if (TIMEOUT < 2) begin
            $error("osc_stop_det: TIMEOUT too small");
        end
    end

    // Cycles since the last tick; a tick clears both count and flag at once.
    always_ff @(posedge clk) begin
        if (!rstn || !enable || main_tick) begin
            gap_r     <= '0;
            stopped_r <= 1'b0;
        end else if (gap_r == LIMIT) begin
            stopped_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 1'b1;
        end
    end

endmodule : osc_stop_det
`default_nettype wire

// [design/clock_ctrl.sv]
// Clock source selection, clock enable generation and main oscillator stop monitor.
//
// Overview of operation
// - Software selects main, PLL, fast internal or slow internal oscillator as source.
// - Main input is crystal or driven clock by a configuration bit, 1 to 20 MHz.
// - PLL multiplier is programmable from times 4 to times 15.5.
// - Fast internal oscillator is set to either 32 MHz or 64 MHz.
// - Separate core, peripheral, flash clocks; core 80 MHz, slower peripherals 40 MHz max.
// - Writes that would take the flash interface clock outside 1 MHz to 32 MHz are refused.
// - Watchdog runs from its own 15 kHz oscillator, apart from system sources.
// - Main oscillator stop while main selected switches source to slow internal oscillator.
// - Main oscillator stop while PLL selected keeps running on PLL free-run frequency.
// - Main oscillator stop forces motor timer outputs to high impedance.
// - That forcing acts only when the stop interrupt is enabled in output control.
// - Oscillator stop can raise an interrupt that cannot be masked.
// - Software standby entry is refused while stop detection is enabled.
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl
    import clock_ctrl_pkg::*;
#(
    parameter int MAIN_KHZ   = 20000,
    parameter int DIV_W      = 3,
    parameter int STOP_LIMIT = STOP_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic [DATA_W-1:0]      rdata_r,
    input  wire logic              main_osc_tick,
    input  wire logic              pll_tick,
    input  wire logic              hirc_tick,
    input  wire logic              lirc_tick,
    input  wire logic              wdt_osc_tick,
    output logic                   system_core_clock,
    output logic                   fast_peripheral_clock,
    output logic                   slow_peripheral_clock,
    output logic                   converter_peripheral_clock,
    output logic                   flash_interface_clock,
    output logic                   watchdog_dedicated_clock,
    output logic [1:0]             active_src_r,
    output logic                   main_ext_clk_r,
    output logic                   hirc_64m_r,
    output logic [4:0]             pll_mul_r,
    output logic                   pll_free_run_r,
    output logic                   motor_timer_hiz_r,
    output logic                   nmi_r,
    output logic                   irq_r,
    output logic                   standby_enter_r
);

    initial begin
        if (MAIN_KHZ < MAIN_MIN_KHZ || MAIN_KHZ > MAIN_MAX_KHZ) begin
            $error("clock_ctrl: MAIN_KHZ outside the main oscillator range");
        end
        if (DIV_W < 1 || DIV_W > 4 || DIV_W > DIV_STRIDE) begin
            $error("clock_ctrl: DIV_W does not fit a divider field");
        end
        if (STOP_LIMIT < 2) begin
            $error("clock_ctrl: STOP_LIMIT too small");
        end
    end

    // Software-visible configuration state.
    clk_src_t          sel_r;
    logic [DATA_W-1:0] div_cfg_r;
    logic              det_en_r;
    logic              stop_irq_en_r;
    logic              stop_flag_r;
    logic              stopped_d_r;
    logic [IRQ_N-1:0]  irq_stat_r;
    logic [IRQ_N-1:0]  irq_en_r;

    // Decoded bus strobes and candidate values.
    logic              wr_src;
    logic              wr_pll;
    logic              wr_div;
    logic              wr_osc;
    logic              wr_irq_clr;
    logic              wr_irq_en;
    logic              wr_stby;
    logic              wr_stop_clr;
    clk_src_t          cand_src;
    logic              cand_hirc;
    logic [4:0]        cand_mul;
    logic [DATA_W-1:0] cand_div;
    logic              cand_ok;
    logic              refuse_evt;
    logic              stby_refuse_evt;
    logic              stopped;
    logic              stop_evt;
    logic              main_running;
    logic              src_tick;
    logic [IRQ_N-1:0]  irq_set;
    logic [IRQ_N-1:0]  irq_clr;
    logic [IRQ_N-1:0]  irq_stat_nxt;
    logic [DATA_W-1:0] rd_val;
    logic [DIV_COUNT-1:0] clk_en;

    // Frequency in kHz of a source under a given setting.
    function automatic logic [31:0] src_khz(input clk_src_t src, input logic [4:0] mul, input logic hirc_hi);
        logic [31:0] f;
        f = 32'(LIRC_KHZ);
        case (src)
            SRC_MAIN: f = 32'(MAIN_KHZ);
            SRC_PLL:  f = (32'(MAIN_KHZ) * 32'(mul)) >> 1;
            SRC_HIRC: f = hirc_hi ? 32'(HIRC_HI_KHZ) : 32'(HIRC_LO_KHZ);
            SRC_LIRC: f = 32'(LIRC_KHZ);
            default:  f = 32'(LIRC_KHZ);
        endcase
        return f;
    endfunction : src_khz

    // Divider field of one derived clock.
    function automatic logic [DIV_W-1:0] div_field(input logic [DATA_W-1:0] cfg, input int idx);
        return cfg[idx*DIV_STRIDE +: DIV_W];
    endfunction : div_field

    // True when every derived clock keeps its frequency limits.
    function automatic logic limits_ok(input logic [31:0] f, input logic [DATA_W-1:0] cfg);
        logic ok;
        ok = 1'b1;
        if ((f >> div_field(cfg, DIV_CORE)) > 32'(CORE_MAX_KHZ) ||
            (f >> div_field(cfg, DIV_FAST)) > 32'(FAST_MAX_KHZ) ||
            (f >> div_field(cfg, DIV_SLOW)) > 32'(SLOW_MAX_KHZ) ||
            (f >> div_field(cfg, DIV_CONV)) > 32'(SLOW_MAX_KHZ)) begin
            ok = 1'b0;
        end
        if ((f >> div_field(cfg, DIV_FLASH)) > 32'(FLASH_MAX_KHZ) ||
            (f >> div_field(cfg, DIV_FLASH)) < 32'(FLASH_MIN_KHZ)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : limits_ok

    // Address decode of the write strobes.
    assign wr_src      = wr_en && (addr == OFS_SRC_CFG);
    assign wr_pll      = wr_en && (addr == OFS_PLL_MUL);
    assign wr_div      = wr_en && (addr == OFS_DIV_CFG);
    assign wr_osc      = wr_en && (addr == OFS_OSC_CTRL);
    assign wr_irq_clr  = wr_en && (addr == OFS_IRQ_CLR);
    assign wr_irq_en   = wr_en && (addr == OFS_IRQ_EN);
    assign wr_stby     = wr_en && (addr == OFS_STANDBY) && wdata[0];
    assign wr_stop_clr = wr_en && (addr == OFS_STOP_CLR) && wdata[0];

    // The configuration that a write would produce, checked as a whole before it is taken.
    always_comb begin
        cand_src  = sel_r;
        cand_hirc = hirc_64m_r;
        cand_mul  = pll_mul_r;
        cand_div  = div_cfg_r;
        if (wr_src) begin
            cand_src  = clk_src_t'(wdata[SRC_LSB +: 2]);
            cand_hirc = wdata[HIRC_HI_BIT];
        end
        if (wr_pll) begin
            cand_mul = wdata[4:0];
        end
        if (wr_div) begin
            cand_div = wdata;
        end
    end

    // A setting that would break a frequency limit is refused and flagged instead.
    assign cand_ok = (cand_mul >= PLL_MUL_MIN) && (cand_mul <= PLL_MUL_MAX) &&
                     limits_ok(src_khz(cand_src, cand_mul, cand_hirc), cand_div);
    assign refuse_evt      = (wr_src || wr_pll || wr_div) && !cand_ok;
    assign stby_refuse_evt = wr_stby && det_en_r;

    // Source, multiplier and divider registers, updated only by accepted writes.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sel_r          <= clk_src_t'(SRC_CFG_RST[SRC_LSB +: 2]);
            main_ext_clk_r <= SRC_CFG_RST[EXT_CLK_BIT];
            hirc_64m_r     <= SRC_CFG_RST[HIRC_HI_BIT];
            pll_mul_r      <= PLL_MUL_RST;
            div_cfg_r      <= DIV_CFG_RST;
        end else if ((wr_src || wr_pll || wr_div) && cand_ok) begin
            sel_r      <= cand_src;
            hirc_64m_r <= cand_hirc;
            pll_mul_r  <= cand_mul;
            div_cfg_r  <= cand_div;
            if (wr_src) begin
                main_ext_clk_r <= wdata[EXT_CLK_BIT];
            end
        end
    end

    // Oscillator control: detection enable and the output-control interrupt enable.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            det_en_r      <= OSC_CTRL_RST[DET_EN_BIT];
            stop_irq_en_r <= OSC_CTRL_RST[STOP_IRQ_BIT];
        end else if (wr_osc) begin
            det_en_r      <= wdata[DET_EN_BIT];
            stop_irq_en_r <= wdata[STOP_IRQ_BIT];
        end
    end

    // Main oscillator stop detector.
    osc_stop_det #(
        .TIMEOUT   (STOP_LIMIT)
    ) u_stop_det (
        .clk       (clk),
        .rstn      (rstn),
        .enable    (det_en_r),
        .main_tick (main_osc_tick),
        .stopped_r (stopped)
    );

    assign stop_evt     = stopped && !stopped_d_r;
    assign main_running = !stopped;

    // The stop flag is sticky; a clear is honoured only once the oscillator runs again,
    // and a new stop in the same cycle wins over the clear.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stop_flag_r <= 1'b0;
            stopped_d_r <= 1'b0;
        end else begin
            stopped_d_r <= stopped;
            if (stop_evt) begin
                stop_flag_r <= 1'b1;
            end else if (wr_stop_clr && main_running) begin
                stop_flag_r <= 1'b0;
            end
        end
    end

    // Effective source: main falls back to the slow oscillator, PLL keeps free running.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            active_src_r   <= SRC_CFG_RST[SRC_LSB +: 2];
            pll_free_run_r <= 1'b0;
        end else begin
            if (stop_flag_r && sel_r == SRC_MAIN) begin
                active_src_r <= SRC_LIRC;
            end else begin
                active_src_r <= sel_r;
            end
            pll_free_run_r <= stop_flag_r && (sel_r == SRC_PLL);
        end
    end

    // Tick of the effective source that feeds every divider.
    always_comb begin
        case (clk_src_t'(active_src_r))
            SRC_MAIN: src_tick = main_osc_tick;
            SRC_PLL:  src_tick = pll_tick;
            SRC_HIRC: src_tick = hirc_tick;
            SRC_LIRC: src_tick = lirc_tick;
            default:  src_tick = lirc_tick;
        endcase
    end

    // One divider per derived clock; all share the source tick so they stay in phase.
    generate
        for (genvar g = 0; g < DIV_COUNT; g++) begin : g_div
            clk_div_en #(
                .DIV_W    (DIV_W)
            ) u_div (
                .clk      (clk),
                .rstn     (rstn),
                .tick_in  (src_tick),
                .div_log2 (div_field(div_cfg_r, g)),
                .en_r     (clk_en[g])
            );
        end
    endgenerate

    assign system_core_clock          = clk_en[DIV_CORE];
    assign fast_peripheral_clock      = clk_en[DIV_FAST];
    assign slow_peripheral_clock      = clk_en[DIV_SLOW];
    assign converter_peripheral_clock = clk_en[DIV_CONV];
    assign flash_interface_clock      = clk_en[DIV_FLASH];

    // The watchdog clock is its own oscillator tick registered one cycle, never from the selected source.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            watchdog_dedicated_clock <= 1'b0;
        end else begin
            watchdog_dedicated_clock <= wdt_osc_tick;
        end
    end

    // Motor timer release and the non-maskable request both follow the sticky stop flag while the output-control interrupt enable is set.
    // The flag, not the raw detector, drives them so a brief recovery cannot re-enable outputs.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            motor_timer_hiz_r <= 1'b0;
            nmi_r             <= 1'b0;
        end else begin
            motor_timer_hiz_r <= stop_flag_r && stop_irq_en_r;
            nmi_r             <= stop_flag_r && stop_irq_en_r;
        end
    end

    // Standby entry: a one-cycle grant, withheld while detection is on.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            standby_enter_r <= 1'b0;
        end else begin
            standby_enter_r <= wr_stby && !det_en_r;
        end
    end

    // Sticky maskable event bits; a set in the clearing cycle survives.
    always_comb begin
        irq_set                 = '0;
        irq_set[IRQ_STOP_BIT]   = stop_evt;
        irq_set[IRQ_REFUSE_BIT] = refuse_evt;
        irq_set[IRQ_STBY_BIT]   = stby_refuse_evt;
        irq_clr                 = wr_irq_clr ? wdata[IRQ_N-1:0] : '0;
        irq_stat_nxt            = (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_r <= '0;
            irq_en_r   <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_irq_en) begin
                irq_en_r <= wdata[IRQ_N-1:0];
            end
            irq_r <= |(irq_stat_nxt & (wr_irq_en ? wdata[IRQ_N-1:0] : irq_en_r));
        end
    end

    // Read mux; write-only and unmapped offsets read as zero.
    always_comb begin
        rd_val = '0;
        case (addr)
            OFS_SRC_CFG: begin
                rd_val[SRC_LSB +: 2]  = sel_r;
                rd_val[EXT_CLK_BIT]   = main_ext_clk_r;
                rd_val[HIRC_HI_BIT]   = hirc_64m_r;
            end
            OFS_PLL_MUL:  rd_val[4:0] = pll_mul_r;
            OFS_DIV_CFG:  rd_val = div_cfg_r;
            OFS_OSC_CTRL: begin
                rd_val[DET_EN_BIT]    = det_en_r;
                rd_val[STOP_IRQ_BIT]  = stop_irq_en_r;
            end
            OFS_STATUS: begin
                rd_val[ST_SRC_LSB +: 2] = active_src_r;
                rd_val[ST_STOP_BIT]     = stop_flag_r;
                rd_val[ST_RUN_BIT]      = main_running;
                rd_val[ST_FREE_BIT]     = pll_free_run_r;
                rd_val[ST_HIZ_BIT]      = motor_timer_hiz_r;
            end
            OFS_IRQ_STAT: rd_val[IRQ_N-1:0] = irq_stat_r;
            OFS_IRQ_EN:   rd_val[IRQ_N-1:0] = irq_en_r;
            default:      rd_val = '0;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rd_en ? rd_val : '0;
        end
    end

endmodule : clock_ctrl
`default_nettype wire

// [tb/clock_ctrl_assertions.sv]
// Port checker for the clock control block, bound into its top module.
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_checker
    import clock_ctrl_pkg::*;
#(parameter int STOP_LIMIT = 8) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [DATA_W-1:0] rdata_r,
    input wire logic              main_osc_tick,
    input wire logic              pll_tick,
    input wire logic              hirc_tick,
    input wire logic              lirc_tick,
    input wire logic              wdt_osc_tick,
    input wire logic              system_core_clock,
    input wire logic              watchdog_dedicated_clock,
    input wire logic [1:0]        active_src_r,
    input wire logic              pll_free_run_r,
    input wire logic              motor_timer_hiz_r,
    input wire logic              nmi_r,
    input wire logic              standby_enter_r
);
    // Cycles since the last main tick, saturating so a long stop never wraps.
    logic [9:0] gap_r;
    always_ff @(posedge clk) begin
        if (!rstn || main_osc_tick) begin
            gap_r <= 10'h000;
        end else if (gap_r != 10'h3FF) begin
            gap_r <= gap_r + 10'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_rd_idle: assert property (!rd_en |=> rdata_r == '0) else $error("read data outside slot");
    chk_stby_cause: assert property (standby_enter_r |-> $past(wr_en) && $past(addr) == OFS_STANDBY)
        else $error("standby grant without request");
    chk_wdt_delay: assert property ($past(rstn) |-> watchdog_dedicated_clock == $past(wdt_osc_tick))
        else $error("watchdog clock not its own tick");
    chk_core_tick: assert property (system_core_clock |-> $past(main_osc_tick | pll_tick | hirc_tick | lirc_tick))
        else $error("core clock without source tick");
    chk_free_src: assert property (pll_free_run_r |-> active_src_r == 2'h1) else $error("free run off pll");
    chk_hiz_gap: assert property ($rose(motor_timer_hiz_r) |-> gap_r >= STOP_LIMIT) else $error("early stop");
    chk_nmi_hiz: assert property ($rose(nmi_r) |-> motor_timer_hiz_r) else $error("nmi without stop");
    chk_hiz_src: assert property ($rose(motor_timer_hiz_r) |-> active_src_r != 2'h0) else $error("main kept");
    // Main scenarios seen at least once.
    cover property ($rose(nmi_r));
    cover property ($rose(pll_free_run_r));
    cover property (standby_enter_r);
endmodule : clock_ctrl_checker
bind clock_ctrl clock_ctrl_checker #(.STOP_LIMIT(STOP_LIMIT)) clock_ctrl_checker_i (.clk, .rstn, .addr,
    .wr_en, .rd_en, .rdata_r, .main_osc_tick, .pll_tick, .hirc_tick, .lirc_tick, .wdt_osc_tick, .system_core_clock,
    .watchdog_dedicated_clock, .active_src_r, .pll_free_run_r, .motor_timer_hiz_r, .nmi_r, .standby_enter_r);
`default_nettype wire

// [tb/osc_bank_model.sv]
// Oscillator bank model feeding tick pulses to the clock control block.
`timescale 1ns/1ps
`default_nettype none
module osc_bank_model (
    input  wire logic clk,
    input  wire logic main_run,
    output logic      main_osc_tick,
    output logic      pll_tick,
    output logic      hirc_tick,
    output logic      lirc_tick,
    output logic      wdt_osc_tick
);
    logic [3:0] ph_r = 4'h0;
    // Free-running phase sets each oscillator's rate but the PLL's, which ticks every cycle; main and fast internal share one, a tick every second cycle.
    always_ff @(posedge clk) begin
        ph_r <= ph_r + 4'h1;
    end
    // A stopped crystal gives no ticks.
    assign main_osc_tick = main_run & ph_r[0];
    assign pll_tick      = 1'b1;
    assign hirc_tick     = ~ph_r[0];
    assign lirc_tick     = ph_r[1:0] == 2'h0;
    assign wdt_osc_tick  = ph_r == 4'hF;
endmodule : osc_bank_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the clock control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clock_ctrl_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, main_run = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata_r;
    logic [1:0]  src;
    logic [4:0]  mul;
    logic        mt, pt, ht, lt, wt, ext_r, hi_r, free_r, hiz_r, nmi_r, irq_r, stby_r;
    int          bad_count = 0, n_tests = 0;
    osc_bank_model osc_bank_model_i (.clk, .main_run, .main_osc_tick(mt), .pll_tick(pt), .hirc_tick(ht),
        .lirc_tick(lt), .wdt_osc_tick(wt));
    clock_ctrl #(.STOP_LIMIT(8)) clock_ctrl_i (.clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata_r,
        .main_osc_tick(mt), .pll_tick(pt), .hirc_tick(ht), .lirc_tick(lt), .wdt_osc_tick(wt),
        .system_core_clock(), .fast_peripheral_clock(), .slow_peripheral_clock(), .converter_peripheral_clock(),
        .flash_interface_clock(), .watchdog_dedicated_clock(), .active_src_r(src), .main_ext_clk_r(ext_r),
        .hirc_64m_r(hi_r), .pll_mul_r(mul), .pll_free_run_r(free_r), .motor_timer_hiz_r(hiz_r), .nmi_r,
        .irq_r, .standby_enter_r(stby_r));
    // Clock, and a cycle ceiling far above the run's length.
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : ck
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        ck(n, e, rdata_r);
    endtask : rd
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : w
    // Bounded wait on a level the design raises.
    task automatic upto(ref logic s);
        for (int i = 0; i < 60 && s !== 1'b1; i++) @(posedge clk);
        @(negedge clk);
    endtask : upto
    task automatic print_verdict();
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    // Reset values, a refused multiplier, every source and an unmapped read.
    task automatic t_cfg();
        ck("src", 3, src);
        wr(OFS_PLL_MUL, 32'h7);
        rd(OFS_IRQ_STAT, 32'h2, "refused");
        ck("mul", 8, mul);
        ck("irq_masked", 0, irq_r);
        wr(OFS_IRQ_CLR, 32'h2);
        wr(OFS_DIV_CFG, 32'h0002_1100);
        wr(OFS_SRC_CFG, 32'h14);
        w(2);
        ck("src", 0, src);
        ck("ext", 1, ext_r);
        ck("hoco64", 1, hi_r);
        for (int s = 1; s < 4; s++) begin
            wr(OFS_SRC_CFG, s);
            w(2);
            ck("src", s, src);
        end
        ck("hoco64", 0, hi_r);
        rd(8'h30, 32'h0, "unmapped");
    endtask : t_cfg
    // Main stop with main selected: fallback, high impedance, interrupts, sticky flag.
    task automatic t_stop();
        wr(OFS_SRC_CFG, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_OSC_CTRL, 32'h3);
        main_run <= 1'b0;
        upto(nmi_r);
        ck("nmi", 1, nmi_r);
        ck("hiz", 1, hiz_r);
        ck("src", 3, src);
        ck("irq", 1, irq_r);
        wr(OFS_STOP_CLR, 32'h1);
        rd(OFS_STATUS, 32'h27, "status");
        main_run <= 1'b1;
        w(4);
        wr(OFS_STOP_CLR, 32'h1);
        wr(OFS_IRQ_CLR, 32'h1);
        w(3);
        ck("src", 0, src);
        ck("hiz", 0, hiz_r);
        ck("irq", 0, irq_r);
    endtask : t_stop
    // Standby refused while detecting, granted once detection is off.
    task automatic t_stby();
        wr(OFS_STANDBY, 32'h1);
        w(0);
        ck("stby", 0, stby_r);
        rd(OFS_IRQ_STAT, 32'h4, "stby_refused");
        wr(OFS_OSC_CTRL, 32'h0);
        wr(OFS_STANDBY, 32'h1);
        w(0);
        ck("stby", 1, stby_r);
    endtask : t_stby
    // Main stop under the PLL with output control off: free run only.
    task automatic t_pll();
        wr(OFS_SRC_CFG, 32'h1);
        wr(OFS_OSC_CTRL, 32'h1);
        main_run <= 1'b0;
        upto(free_r);
        ck("free", 1, free_r);
        ck("src", 1, src);
        ck("hiz", 0, hiz_r);
    endtask : t_pll
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_cfg();
        t_stop();
        t_stby();
        t_pll();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
